// >>> include/cpu_ctl_pkg.sv
// Constants and types for the control-register and block-move unit.
// Assumes a single 20 MHz clock where one state is one clock cycle.
package cpu_ctl_pkg;
  // ==========================================
  // Widths
  localparam int ADDR_W = 24;
  localparam int FIFO_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] FIFO_LAST_LVL = 4'h7;
  localparam logic [ADDR_W-1:0] PREDEC_STEP = 24'h000002;
  // ==========================================
  // Flag positions and reset values
  localparam int FL_C = 0;
  localparam int FL_V = 1;
  localparam int FL_Z = 2;
  localparam int FL_N = 3;
  localparam int FL_H = 5;
  // Carry into these bits is carry out of bits 3, 11 and 27
  localparam int HB_BYTE = 4;
  localparam int HB_WORD = 12;
  localparam int HB_LONG = 28;
  localparam logic [7:0] CCR_RST = 8'h80;
  localparam logic [7:0] EXR_RST = 8'h07;
  // ==========================================
  // State counts
  localparam logic [4:0] CCR_OP_ST = 5'h01;
  localparam logic [4:0] EXR_OP_ST = 5'h02;
  localparam logic [4:0] FLAG_OP_ST = 5'h01;
  localparam logic [4:0] STC_BASE_ST = 5'h01;
  localparam logic [4:0] PREDEC_ST = 5'h01;
  localparam logic [4:0] EXR_EXTRA_ST = 5'h01;
  localparam logic [4:0] MOVE_PRE_ST = 5'h04;
  localparam logic [4:0] MOVE_POST_ST = 5'h02;
  localparam logic [5:0] ONE_ST = 6'h01;
  localparam logic [5:0] TWO_ST = 6'h02;
  localparam logic [5:0] FOUR_ST = 6'h04;
  localparam logic [5:0] EXT_BYTE_ST = 6'h03;
  localparam logic [5:0] EXT_WORD8_ST = 6'h06;
  // ==========================================
  // Enumerations
  typedef enum logic [3:0] {
    OP_AND_IMMEDIATE_CONTROL_CCR = 4'h0, OP_ORC_CCR = 4'h1, OP_XOR_IMMEDIATE_CONTROL_CCR = 4'h2,
    OP_AND_IMMEDIATE_CONTROL_EXR = 4'h3, OP_ORC_EXR = 4'h4, OP_XOR_IMMEDIATE_CONTROL_EXR = 4'h5,
    OP_STC_CCR = 4'h6, OP_STC_EXR = 4'h7, OP_MOVE_B = 4'h8,
    OP_MOVE_W = 4'h9, OP_FLAGS = 4'hA
  } op_t;
  typedef enum logic [2:0] {
    R_ONCHIP = 3'h0, R_MOD8 = 3'h1, R_MOD16 = 3'h2, R_EXT8_2 = 3'h3,
    R_EXT8_3 = 3'h4, R_EXT16_2 = 3'h5, R_EXT16_3 = 3'h6
  } region_t;
  typedef enum logic [2:0] {
    FM_ADD = 3'h0, FM_SUB = 3'h1, FM_EXT = 3'h2, FM_DIVU = 3'h3,
    FM_DIVS = 3'h4
  } flag_mode_t;
  typedef enum logic [1:0] {SZ_B = 2'h0, SZ_W = 2'h1, SZ_L = 2'h2} size_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'h1, S_WAIT = 4'h2, S_MOVE = 4'h4, S_STORE = 4'h8
  } state_t;
endpackage

// >>> rtl/access_cost.sv
// States taken by one memory access, by region, size and wait states.
// Assumes the region code is steady while an access is issued.
`timescale 1ns/1ns
module access_cost (
  // Access description
  input wire cpu_ctl_pkg::region_t region_i,
  input wire logic [3:0] wait_i,
  input wire logic word_i,
  // Result
  output logic [5:0] cost_o
);
  logic [5:0] m;
  assign m = {2'h0, wait_i};
  // ==========================================
  // Cost table
  always_comb begin
    unique case (region_i)
      cpu_ctl_pkg::R_ONCHIP: cost_o = cpu_ctl_pkg::ONE_ST;
      cpu_ctl_pkg::R_MOD8, cpu_ctl_pkg::R_EXT8_2: begin
        cost_o = word_i ? cpu_ctl_pkg::FOUR_ST : cpu_ctl_pkg::TWO_ST;
      end
      cpu_ctl_pkg::R_MOD16, cpu_ctl_pkg::R_EXT16_2: begin
        cost_o = cpu_ctl_pkg::TWO_ST;
      end
      cpu_ctl_pkg::R_EXT8_3: begin
        cost_o = word_i ? cpu_ctl_pkg::EXT_WORD8_ST + {m[4:0], 1'b0}
                        : cpu_ctl_pkg::EXT_BYTE_ST + m;
      end
      cpu_ctl_pkg::R_EXT16_3: cost_o = cpu_ctl_pkg::EXT_BYTE_ST + m;
      default: cost_o = cpu_ctl_pkg::ONE_ST;
    endcase
  end
endmodule

// >>> rtl/cpu_ctl_exec.sv
// Control-register operations, flag update and block move unit.
// Assumes a memory port on the same clock that ends each access
// after the state count given by the region pins.
// Operation
// - Byte move copies until 8-bit count zero
// - Word-count move uses 16-bit count register
// - Move takes four plus two plus per-byte states
// - Base counts assume one-state word memory
// - Valid extended register adds one state
// - Word half-carry from bit eleven carry
// - Longword half-carry from bit twenty-seven carry
// - Extended ops keep zero only on zero
// - Unsigned division negative flag follows divisor sign
// - Division zero flag marks zero divisor
// - Signed division negative flag follows quotient
// - Slow module or bus access costs more
// - Wait states extend three-state external accesses
// - On-chip accesses take one state
// - Unaffected flags keep their values
// - Result-dependent flags follow operation outcome
`timescale 1ns/1ns
module cpu_ctl_exec (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic NRST_I,
  // Command
  input wire logic CMD_VALID_I,
  input wire cpu_ctl_pkg::op_t CMD_OP_I,
  input wire logic [7:0] CMD_IMM_I,
  input wire logic CMD_EXR_EXTRA_I,
  input wire logic CMD_PREDEC_I,
  input wire logic [23:0] CMD_ADDR_I,
  output logic CMD_READY_O,
  output logic DONE_O,
  output logic [23:0] STATES_O,
  // Configuration
  input wire logic EXR_VALID_I,
  input wire cpu_ctl_pkg::region_t MEM_REGION_I,
  input wire logic [3:0] WAIT_STATES_I,
  // Flag update operands
  input wire cpu_ctl_pkg::flag_mode_t FLG_MODE_I,
  input wire cpu_ctl_pkg::size_t FLG_SIZE_I,
  input wire logic FLG_SUB_I,
  input wire logic [31:0] OPA_I,
  input wire logic [31:0] OPB_I,
  input wire logic [31:0] RES_I,
  // Block move setup
  input wire logic [23:0] MOVE_SRC_I,
  input wire logic [23:0] MOVE_DST_I,
  input wire logic [15:0] MOVE_CNT_I,
  // Memory port
  output logic MEM_REQ_O,
  output logic MEM_WE_O,
  output logic MEM_WORD_O,
  output logic [23:0] MEM_ADDR_O,
  output logic [15:0] MEM_WDATA_O,
  input wire logic [15:0] MEM_RDATA_I,
  // Register state
  output logic [7:0] CONDITION_CODE_REG_O,
  output logic [7:0] EXTENDED_CONTROL_REG_O,
  output logic [23:0] MOVE_SOURCE_POINTER_O,
  output logic [23:0] MOVE_DEST_POINTER_O,
  output logic [15:0] WORD_MOVE_COUNT_O,
  output logic [23:0] DEST_POINTER_REG_O
);
  // ==========================================
  // Helpers
  function automatic logic msb_of(input logic [31:0] v,
                                  input cpu_ctl_pkg::size_t s);
    unique case (s)
      cpu_ctl_pkg::SZ_B: return v[7];
      cpu_ctl_pkg::SZ_W: return v[15];
      default: return v[31];
    endcase
  endfunction
  function automatic logic zero_of(input logic [31:0] v,
                                   input cpu_ctl_pkg::size_t s);
    unique case (s)
      cpu_ctl_pkg::SZ_B: return v[7:0] == 8'h00;
      cpu_ctl_pkg::SZ_W: return v[15:0] == 16'h0000;
      default: return v == 32'h00000000;
    endcase
  endfunction
  // ==========================================
  // Declarations
  cpu_ctl_pkg::state_t st;
  cpu_ctl_pkg::state_t next_st;
  cpu_ctl_pkg::state_t wait_next;
  logic [4:0] wait_left;
  logic [4:0] op_st;
  logic [23:0] st_cnt;
  logic [7:0] next_ccr;
  logic [7:0] store_data;
  logic [15:0] rd_left;
  logic [15:0] wr_left;
  logic mv_byte;
  logic [5:0] acc_left;
  logic [5:0] cost;
  logic cmd_go, extra, finish, acc_end, port_free;
  logic rd_go, wr_go, st_go, push, room, move_end;
  logic fifo_in_ready, fifo_out_valid;
  logic [7:0] fifo_out;
  logic [3:0] level;
  logic a, b, r, x_h, carry, ovf;
  logic [31:0] x;
  assign cmd_go = CMD_VALID_I && CMD_READY_O;
  assign extra = CMD_EXR_EXTRA_I && EXR_VALID_I;
  // ==========================================
  // Sequencer
  always_comb begin
    next_st = st;
    unique case (st)
      cpu_ctl_pkg::S_IDLE: if (cmd_go) next_st = cpu_ctl_pkg::S_WAIT;
      cpu_ctl_pkg::S_WAIT: if (wait_left == 5'h01) next_st = wait_next;
      cpu_ctl_pkg::S_MOVE: if (move_end) next_st = cpu_ctl_pkg::S_WAIT;
      cpu_ctl_pkg::S_STORE: if (acc_end) next_st = cpu_ctl_pkg::S_IDLE;
    endcase
  end
  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      st <= cpu_ctl_pkg::S_IDLE;
      CMD_READY_O <= 1'b0;
    end else begin
      st <= next_st;
      CMD_READY_O <= next_st == cpu_ctl_pkg::S_IDLE;
    end
  end
  // Issue cycle of the first access is counted inside the lead-in
  always_comb begin
    unique case (CMD_OP_I)
      cpu_ctl_pkg::OP_AND_IMMEDIATE_CONTROL_CCR, cpu_ctl_pkg::OP_ORC_CCR,
      cpu_ctl_pkg::OP_XOR_IMMEDIATE_CONTROL_CCR: op_st = cpu_ctl_pkg::CCR_OP_ST;
      cpu_ctl_pkg::OP_AND_IMMEDIATE_CONTROL_EXR, cpu_ctl_pkg::OP_ORC_EXR,
      cpu_ctl_pkg::OP_XOR_IMMEDIATE_CONTROL_EXR: op_st = cpu_ctl_pkg::EXR_OP_ST;
      cpu_ctl_pkg::OP_STC_CCR, cpu_ctl_pkg::OP_STC_EXR: begin
        op_st = CMD_PREDEC_I
              ? cpu_ctl_pkg::STC_BASE_ST + cpu_ctl_pkg::PREDEC_ST
              : cpu_ctl_pkg::STC_BASE_ST;
      end
      cpu_ctl_pkg::OP_MOVE_B, cpu_ctl_pkg::OP_MOVE_W: begin
        op_st = cpu_ctl_pkg::MOVE_PRE_ST - 5'h01;
      end
      default: op_st = cpu_ctl_pkg::FLAG_OP_ST;
    endcase
  end
  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      wait_left <= 5'h00;
      wait_next <= cpu_ctl_pkg::S_IDLE;
    end else if (st == cpu_ctl_pkg::S_IDLE && cmd_go) begin
      wait_left <= extra ? op_st + cpu_ctl_pkg::EXR_EXTRA_ST : op_st;
      if (CMD_OP_I == cpu_ctl_pkg::OP_STC_CCR ||
          CMD_OP_I == cpu_ctl_pkg::OP_STC_EXR) begin
        wait_next <= cpu_ctl_pkg::S_STORE;
      end else if (CMD_OP_I == cpu_ctl_pkg::OP_MOVE_B ||
                   CMD_OP_I == cpu_ctl_pkg::OP_MOVE_W) begin
        wait_next <= cpu_ctl_pkg::S_MOVE;
      end else begin
        wait_next <= cpu_ctl_pkg::S_IDLE;
      end
    end else if (move_end) begin
      wait_left <= cpu_ctl_pkg::MOVE_POST_ST;
      wait_next <= cpu_ctl_pkg::S_IDLE;
    end else if (wait_left != 5'h00) begin
      wait_left <= wait_left - 5'h01;
    end
  end
  // ==========================================
  // State count of the last instruction
  assign finish = (st == cpu_ctl_pkg::S_WAIT && wait_left == 5'h01 &&
                   wait_next == cpu_ctl_pkg::S_IDLE) ||
                  (st == cpu_ctl_pkg::S_STORE && acc_end);
  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      st_cnt <= 24'h000000;
      STATES_O <= 24'h000000;
      DONE_O <= 1'b0;
    end else begin
      st_cnt <= (st == cpu_ctl_pkg::S_IDLE) ? 24'h000000
                                           : st_cnt + 24'h000001;
      if (finish) STATES_O <= st_cnt + 24'h000001;
      DONE_O <= finish;
    end
  end
  // ==========================================
  // Flag evaluation
  assign x = OPA_I ^ OPB_I ^ RES_I;
  assign a = msb_of(OPA_I, FLG_SIZE_I);
  assign b = msb_of(OPB_I, FLG_SIZE_I);
  assign r = msb_of(RES_I, FLG_SIZE_I);
  assign x_h = (FLG_SIZE_I == cpu_ctl_pkg::SZ_B) ? x[cpu_ctl_pkg::HB_BYTE]
             : (FLG_SIZE_I == cpu_ctl_pkg::SZ_W) ? x[cpu_ctl_pkg::HB_WORD]
             : x[cpu_ctl_pkg::HB_LONG];
  assign carry = FLG_SUB_I ? ((~a & b) | ((~a | b) & r))
                           : ((a & b) | ((a | b) & ~r));
  assign ovf = FLG_SUB_I ? ((a ^ b) & (a ^ r)) : ((a ~^ b) & (a ^ r));
  always_comb begin
    next_ccr = CONDITION_CODE_REG_O;
    unique case (FLG_MODE_I)
      cpu_ctl_pkg::FM_ADD, cpu_ctl_pkg::FM_SUB, cpu_ctl_pkg::FM_EXT: begin
        next_ccr[cpu_ctl_pkg::FL_H] = x_h;
        next_ccr[cpu_ctl_pkg::FL_N] = r;
        next_ccr[cpu_ctl_pkg::FL_V] = ovf;
        next_ccr[cpu_ctl_pkg::FL_C] = carry;
        if (FLG_MODE_I != cpu_ctl_pkg::FM_EXT) begin
          next_ccr[cpu_ctl_pkg::FL_Z] = zero_of(RES_I, FLG_SIZE_I);
        end else if (!zero_of(RES_I, FLG_SIZE_I)) begin
          next_ccr[cpu_ctl_pkg::FL_Z] = 1'b0;
        end
      end
      cpu_ctl_pkg::FM_DIVU: begin
        next_ccr[cpu_ctl_pkg::FL_N] = b;
        next_ccr[cpu_ctl_pkg::FL_Z] = zero_of(OPB_I, FLG_SIZE_I);
      end
      cpu_ctl_pkg::FM_DIVS: begin
        next_ccr[cpu_ctl_pkg::FL_N] = r;
        next_ccr[cpu_ctl_pkg::FL_Z] = zero_of(OPB_I, FLG_SIZE_I);
      end
      default: next_ccr = CONDITION_CODE_REG_O;
    endcase
  end
  // ==========================================
  // Control registers
  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      CONDITION_CODE_REG_O <= cpu_ctl_pkg::CCR_RST;
    end else if (cmd_go) begin
      unique case (CMD_OP_I)
        cpu_ctl_pkg::OP_AND_IMMEDIATE_CONTROL_CCR:
          CONDITION_CODE_REG_O <= CONDITION_CODE_REG_O & CMD_IMM_I;
        cpu_ctl_pkg::OP_ORC_CCR:
          CONDITION_CODE_REG_O <= CONDITION_CODE_REG_O | CMD_IMM_I;
        cpu_ctl_pkg::OP_XOR_IMMEDIATE_CONTROL_CCR:
          CONDITION_CODE_REG_O <= CONDITION_CODE_REG_O ^ CMD_IMM_I;
        cpu_ctl_pkg::OP_FLAGS: CONDITION_CODE_REG_O <= next_ccr;
        default: CONDITION_CODE_REG_O <= CONDITION_CODE_REG_O;
      endcase
    end
  end
  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      EXTENDED_CONTROL_REG_O <= cpu_ctl_pkg::EXR_RST;
    end else if (cmd_go) begin
      unique case (CMD_OP_I)
        cpu_ctl_pkg::OP_AND_IMMEDIATE_CONTROL_EXR:
          EXTENDED_CONTROL_REG_O <= EXTENDED_CONTROL_REG_O & CMD_IMM_I;
        cpu_ctl_pkg::OP_ORC_EXR:
          EXTENDED_CONTROL_REG_O <= EXTENDED_CONTROL_REG_O | CMD_IMM_I;
        cpu_ctl_pkg::OP_XOR_IMMEDIATE_CONTROL_EXR:
          EXTENDED_CONTROL_REG_O <= EXTENDED_CONTROL_REG_O ^ CMD_IMM_I;
        default: EXTENDED_CONTROL_REG_O <= EXTENDED_CONTROL_REG_O;
      endcase
    end
  end
  // Store target is fixed at accept so later pointer writes cannot race
  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      DEST_POINTER_REG_O <= 24'h000000;
      store_data <= 8'h00;
    end else if (cmd_go && (CMD_OP_I == cpu_ctl_pkg::OP_STC_CCR ||
                            CMD_OP_I == cpu_ctl_pkg::OP_STC_EXR)) begin
      DEST_POINTER_REG_O <= CMD_PREDEC_I
                          ? CMD_ADDR_I - cpu_ctl_pkg::PREDEC_STEP
                          : CMD_ADDR_I;
      store_data <= (CMD_OP_I == cpu_ctl_pkg::OP_STC_EXR)
                  ? EXTENDED_CONTROL_REG_O : CONDITION_CODE_REG_O;
    end
  end
  // ==========================================
  // Memory access engine, one access in flight
  assign acc_end = MEM_REQ_O && acc_left == 6'h01;
  assign port_free = !MEM_REQ_O || acc_end;
  assign push = acc_end && !MEM_WE_O && st == cpu_ctl_pkg::S_MOVE;
  // A read ending this cycle still needs its slot
  assign room = fifo_in_ready &&
                !(push && level == cpu_ctl_pkg::FIFO_LAST_LVL);
  assign rd_go = st == cpu_ctl_pkg::S_MOVE && port_free &&
                 rd_left != 16'h0000 && room;
  assign wr_go = st == cpu_ctl_pkg::S_MOVE && port_free && !rd_go &&
                 fifo_out_valid;
  assign st_go = st == cpu_ctl_pkg::S_STORE && !MEM_REQ_O;
  assign move_end = st == cpu_ctl_pkg::S_MOVE &&
                    ((wr_left == 16'h0000 && !MEM_REQ_O) ||
                     (acc_end && MEM_WE_O && wr_left == 16'h0001));
  access_cost cost_u (
    .region_i(MEM_REGION_I),
    .wait_i(WAIT_STATES_I),
    .word_i(st == cpu_ctl_pkg::S_STORE),
    .cost_o(cost)
  );
  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      MEM_REQ_O <= 1'b0;
      MEM_WE_O <= 1'b0;
      MEM_WORD_O <= 1'b0;
      MEM_ADDR_O <= 24'h000000;
      MEM_WDATA_O <= 16'h0000;
      acc_left <= 6'h00;
    end else if (rd_go || wr_go || st_go) begin
      MEM_REQ_O <= 1'b1;
      MEM_WE_O <= !rd_go;
      MEM_WORD_O <= st_go;
      MEM_ADDR_O <= rd_go ? MOVE_SOURCE_POINTER_O
                  : wr_go ? MOVE_DEST_POINTER_O : DEST_POINTER_REG_O;
      MEM_WDATA_O <= st_go ? {store_data, store_data}
                           : {8'h00, fifo_out};
      acc_left <= cost;
    end else if (acc_end) begin
      MEM_REQ_O <= 1'b0;
      acc_left <= 6'h00;
    end else if (MEM_REQ_O) begin
      acc_left <= acc_left - 6'h01;
    end
  end
  // ==========================================
  // Block move pointers and counts
  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      MOVE_SOURCE_POINTER_O <= 24'h000000;
      MOVE_DEST_POINTER_O <= 24'h000000;
      WORD_MOVE_COUNT_O <= 16'h0000;
      rd_left <= 16'h0000;
      wr_left <= 16'h0000;
      mv_byte <= 1'b0;
    end else if (cmd_go && (CMD_OP_I == cpu_ctl_pkg::OP_MOVE_B ||
                            CMD_OP_I == cpu_ctl_pkg::OP_MOVE_W)) begin
      mv_byte <= CMD_OP_I == cpu_ctl_pkg::OP_MOVE_B;
      MOVE_SOURCE_POINTER_O <= MOVE_SRC_I;
      MOVE_DEST_POINTER_O <= MOVE_DST_I;
      WORD_MOVE_COUNT_O <= MOVE_CNT_I;
      if (CMD_OP_I == cpu_ctl_pkg::OP_MOVE_B) begin
        rd_left <= {8'h00, MOVE_CNT_I[7:0]};
        wr_left <= {8'h00, MOVE_CNT_I[7:0]};
      end else begin
        rd_left <= MOVE_CNT_I;
        wr_left <= MOVE_CNT_I;
      end
    end else begin
      if (rd_go) begin
        MOVE_SOURCE_POINTER_O <= MOVE_SOURCE_POINTER_O + 24'h000001;
        rd_left <= rd_left - 16'h0001;
      end
      if (wr_go) begin
        MOVE_DEST_POINTER_O <= MOVE_DEST_POINTER_O + 24'h000001;
      end
      if (acc_end && MEM_WE_O && st == cpu_ctl_pkg::S_MOVE) begin
        wr_left <= wr_left - 16'h0001;
        if (mv_byte) begin
          WORD_MOVE_COUNT_O[7:0] <= WORD_MOVE_COUNT_O[7:0] - 8'h01;
        end else begin
          WORD_MOVE_COUNT_O <= WORD_MOVE_COUNT_O - 16'h0001;
        end
      end
    end
  end
  // Reads run ahead until the buffer fills or no reads remain, then writes drain it
  stage_fifo #(
    .W(cpu_ctl_pkg::FIFO_W),
    .DEPTH(cpu_ctl_pkg::FIFO_DEPTH),
    .AW(3)
  ) fifo_u (
    .clk_i(MCLK_I),
    .nrst_i(NRST_I),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(MEM_RDATA_I[7:0]),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(wr_go),
    .out_data_o(fifo_out),
    .level_o(level)
  );
  // ==========================================
  // Checks
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!NRST_I);
  sequence s_busy_two;
    !CMD_READY_O ##1 !CMD_READY_O ##1 CMD_READY_O;
  endsequence
  sequence s_empty_move;
    (!MEM_REQ_O)[*6] ##1 (DONE_O && STATES_O == 24'h000006);
  endsequence
  ccr_and_op_a:
    assert property (cmd_go && CMD_OP_I == cpu_ctl_pkg::OP_AND_IMMEDIATE_CONTROL_CCR |=>
      CONDITION_CODE_REG_O == ($past(CONDITION_CODE_REG_O) &
                               $past(CMD_IMM_I)))
    else $error("condition code AND result wrong");
  exr_op_time_a:
    assert property (cmd_go && CMD_OP_I == cpu_ctl_pkg::OP_XOR_IMMEDIATE_CONTROL_EXR &&
      !extra |=> s_busy_two)
    else $error("extended logic op not two states");
  empty_move_a:
    assert property (cmd_go && CMD_OP_I == cpu_ctl_pkg::OP_MOVE_B &&
      MOVE_CNT_I[7:0] == 8'h00 && !extra |=> s_empty_move)
    else $error("zero count move wrong");
  byte_count_a:
    assert property (acc_end && MEM_WE_O && st == cpu_ctl_pkg::S_MOVE &&
      mv_byte |=> WORD_MOVE_COUNT_O[15:8] == $past(WORD_MOVE_COUNT_O[15:8])
      && WORD_MOVE_COUNT_O[7:0] == $past(WORD_MOVE_COUNT_O[7:0]) - 8'h01)
    else $error("byte count step wrong");
  src_step_a:
    assert property (rd_go |=> MEM_ADDR_O + 24'h000001 ==
      MOVE_SOURCE_POINTER_O && !MEM_WE_O)
    else $error("source pointer step wrong");
  onchip_cost_a:
    assert property (rd_go && MEM_REGION_I == cpu_ctl_pkg::R_ONCHIP |=>
      acc_end)
    else $error("on-chip access not one state");
  ext_word_cost_a:
    assert property (st_go && MEM_REGION_I == cpu_ctl_pkg::R_EXT8_3 |=>
      acc_left == 6'h06 + {1'b0, $past(WAIT_STATES_I), 1'b0})
    else $error("external word cost wrong");
  store_flags_a:
    assert property (st == cpu_ctl_pkg::S_STORE |=>
      $stable(CONDITION_CODE_REG_O) &&
      (!MEM_REQ_O || MEM_ADDR_O == DEST_POINTER_REG_O))
    else $error("store disturbed flags or address");
  ext_zero_a:
    assert property (cmd_go && CMD_OP_I == cpu_ctl_pkg::OP_FLAGS &&
      FLG_MODE_I == cpu_ctl_pkg::FM_EXT && zero_of(RES_I, FLG_SIZE_I) |=>
      $stable(CONDITION_CODE_REG_O[cpu_ctl_pkg::FL_Z]))
    else $error("extended zero flag not kept");
  div_zero_a:
    assert property (cmd_go && CMD_OP_I == cpu_ctl_pkg::OP_FLAGS &&
      FLG_MODE_I == cpu_ctl_pkg::FM_DIVU |=>
      CONDITION_CODE_REG_O[cpu_ctl_pkg::FL_Z] ==
      zero_of($past(OPB_I), $past(FLG_SIZE_I)))
    else $error("division zero flag wrong");
endmodule

// >>> rtl/stage_fifo.sv
// Small first-in first-out store with valid/ready on both sides.
// Assumes the same clock and synchronous reset on both sides.
`timescale 1ns/1ns
module stage_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o,
  output logic [AW:0] level_o
);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wptr;
  logic [AW:0] rptr;
  // ==========================================
  // Pointers carry a wrap bit so full and empty differ
  assign level_o = wptr - rptr;
  assign in_ready_o = level_o != (AW+1)'(DEPTH);
  assign out_valid_o = wptr != rptr;
  assign out_data_o = mem[rptr[AW-1:0]];
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      wptr <= '0;
    end else if (in_valid_i && in_ready_o) begin
      wptr <= wptr + 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (in_valid_i && in_ready_o) begin
      mem[wptr[AW-1:0]] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rptr <= '0;
    end else if (out_valid_o && out_ready_i) begin
      rptr <= rptr + 1'b1;
    end
  end
endmodule

// >>> test/mem_model.sv
// Byte memory on the far side of the unit's memory port.
// Assumes one access in flight, with data in the low byte.
`timescale 1ns/1ns
module mem_model (
  // Clock
  input wire logic clk_i,
  // Access
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [23:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o
);
  logic [7:0] mem [256];
  logic [15:0] last;
  initial begin
    last = 16'h0000;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
  end
  // Idle bus shows inverse of last value, so stale data cannot pass
  always_comb begin
    rdata_o = (req_i && !we_i) ? {8'h00, mem[addr_i[7:0]]} : ~last;
  end
  always @(posedge clk_i) begin
    if (req_i && we_i) begin
      mem[addr_i[7:0]] <= wdata_i[7:0];
    end
    if (req_i && !we_i) begin
      last <= rdata_o;
    end
  end
endmodule

// >>> test/tb.sv
// Self-checking bench for the control-register and block-move unit.
// Assumes the unit idles with ready high between commands.
`timescale 1ns/1ns
module tb;
  logic clk = 0, nrst = 0, valid = 0, extra = 0, predec = 0, exr_v = 0;
  logic fsub = 0, ready, done, req, we, word;
  cpu_ctl_pkg::op_t op = cpu_ctl_pkg::OP_FLAGS;
  cpu_ctl_pkg::region_t reg_sel = cpu_ctl_pkg::R_ONCHIP;
  cpu_ctl_pkg::flag_mode_t fm = cpu_ctl_pkg::FM_ADD;
  cpu_ctl_pkg::size_t fs = cpu_ctl_pkg::SZ_W;
  logic [7:0] imm = 8'h00, condition_code_reg, extended_control_reg;
  logic [3:0] ws = 4'h0;
  logic [31:0] opa = 32'h0, opb = 32'h0, res = 32'h0;
  logic [23:0] addr = 24'h0, src = 24'h0, dst = 24'h0, states, maddr;
  logic [23:0] sp, dp, dpr;
  logic [15:0] cnt = 16'h0, wdata, rdata, wc;
  int fail_count = 0, check_count = 0;
  cpu_ctl_exec u_dut (.MCLK_I(clk), .NRST_I(nrst), .CMD_VALID_I(valid),
    .CMD_OP_I(op), .CMD_IMM_I(imm), .CMD_EXR_EXTRA_I(extra),
    .CMD_PREDEC_I(predec), .CMD_ADDR_I(addr), .CMD_READY_O(ready),
    .DONE_O(done), .STATES_O(states), .EXR_VALID_I(exr_v),
    .MEM_REGION_I(reg_sel), .WAIT_STATES_I(ws), .FLG_MODE_I(fm),
    .FLG_SIZE_I(fs), .FLG_SUB_I(fsub), .OPA_I(opa), .OPB_I(opb),
    .RES_I(res), .MOVE_SRC_I(src), .MOVE_DST_I(dst), .MOVE_CNT_I(cnt),
    .MEM_REQ_O(req), .MEM_WE_O(we), .MEM_WORD_O(word),
    .MEM_ADDR_O(maddr), .MEM_WDATA_O(wdata), .MEM_RDATA_I(rdata),
    .CONDITION_CODE_REG_O(condition_code_reg), .EXTENDED_CONTROL_REG_O(extended_control_reg),
    .MOVE_SOURCE_POINTER_O(sp), .MOVE_DEST_POINTER_O(dp),
    .WORD_MOVE_COUNT_O(wc), .DEST_POINTER_REG_O(dpr));
  mem_model u_mem (.clk_i(clk), .req_i(req), .we_i(we), .addr_i(maddr),
    .wdata_i(wdata), .rdata_o(rdata));
  initial begin
    forever #25 clk = ~clk;
  end
  // ==========================================
  // Checking
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Issue one command, wait bounded for completion, check state count
  task automatic run(input cpu_ctl_pkg::op_t o, input logic [23:0] n);
    @(negedge clk) op = o;
    valid = 1'b1;
    @(negedge clk) valid = 1'b0;
    for (int i = 0; i < 300 && done !== 1'b1; i++) @(negedge clk);
    if (done !== 1'b1) begin
      fail_count++;
      results();
    end else begin
      chk(states, n);
      chk(ready, 1'b1);
    end
  endtask
  // ==========================================
  // Scenarios
  task automatic logic_ops();
    imm = 8'h0F;
    run(cpu_ctl_pkg::OP_AND_IMMEDIATE_CONTROL_CCR, 24'h1);
    chk(condition_code_reg, 8'h00);
    imm = 8'hA0;
    run(cpu_ctl_pkg::OP_ORC_CCR, 24'h1);
    chk(condition_code_reg, 8'hA0);
    imm = 8'hFF;
    run(cpu_ctl_pkg::OP_XOR_IMMEDIATE_CONTROL_CCR, 24'h1);
    chk(condition_code_reg, 8'h5F);
    imm = 8'h03;
    run(cpu_ctl_pkg::OP_AND_IMMEDIATE_CONTROL_EXR, 24'h2);
    chk(extended_control_reg, 8'h03);
    imm = 8'h80;
    extra = 1;
    exr_v = 1;
    run(cpu_ctl_pkg::OP_ORC_EXR, 24'h3);
    chk(extended_control_reg, 8'h83);
    // Flagged op with the register not valid gets no extra state
    imm = 8'h01;
    exr_v = 0;
    run(cpu_ctl_pkg::OP_XOR_IMMEDIATE_CONTROL_EXR, 24'h2);
    chk(extended_control_reg, 8'h82);
    extra = 0;
  endtask
  task automatic stores();
    addr = 24'h20;
    predec = 1;
    run(cpu_ctl_pkg::OP_STC_CCR, 24'h4);
    chk(dpr, 24'h1E);
    chk(u_mem.mem[8'h1E], 8'h5F);
    chk(condition_code_reg, 8'h5F);
    addr = 24'h30;
    predec = 0;
    reg_sel = cpu_ctl_pkg::R_EXT8_3;
    ws = 4'h1;
    run(cpu_ctl_pkg::OP_STC_EXR, 24'hA);
    chk(u_mem.mem[8'h30], 8'h82);
    chk(dpr, 24'h30);
    addr = 24'h34;
    reg_sel = cpu_ctl_pkg::R_MOD8;
    run(cpu_ctl_pkg::OP_STC_CCR, 24'h6);
    chk(u_mem.mem[8'h34], 8'h5F);
    chk(word, 1'b1);
    reg_sel = cpu_ctl_pkg::R_ONCHIP;
    ws = 4'h0;
  endtask
  task automatic moves();
    cnt = 16'h0100;
    run(cpu_ctl_pkg::OP_MOVE_B, 24'h6);
    chk(wc, 16'h0100);
    chk(u_mem.mem[8'h00], 8'h5A);
    cnt = 16'h0103;
    src = 24'h40;
    dst = 24'h80;
    run(cpu_ctl_pkg::OP_MOVE_B, 24'hC);
    chk(wc, 16'h0100);
    chk(sp, 24'h43);
    chk(dp, 24'h83);
    chk(u_mem.mem[8'h82], 8'h18);
    cnt = 16'h0002;
    src = 24'h50;
    dst = 24'h90;
    run(cpu_ctl_pkg::OP_MOVE_W, 24'hA);
    chk(wc, 16'h0);
    chk(u_mem.mem[8'h91], 8'h0B);
    chk(dp, 24'h92);
  endtask
  task automatic flags();
    opa = 32'h0800;
    opb = 32'h0800;
    res = 32'h1000;
    run(cpu_ctl_pkg::OP_FLAGS, 24'h1);
    chk(condition_code_reg[5], 1'b1);
    fs = cpu_ctl_pkg::SZ_L;
    opa = 32'h0800_0000;
    opb = 32'h0800_0000;
    res = 32'h1000_0000;
    run(cpu_ctl_pkg::OP_FLAGS, 24'h1);
    chk(condition_code_reg[5], 1'b1);
    // Borrow through every bit: H, N and C set, Z and V clear
    fm = cpu_ctl_pkg::FM_SUB;
    fsub = 1;
    opa = 32'h0;
    opb = 32'h1;
    res = 32'hFFFF_FFFF;
    run(cpu_ctl_pkg::OP_FLAGS, 24'h1);
    chk(condition_code_reg, 8'h79);
    fm = cpu_ctl_pkg::FM_DIVS;
    opb = 32'h0;
    res = 32'h8000_0000;
    run(cpu_ctl_pkg::OP_FLAGS, 24'h1);
    chk(condition_code_reg[3:2], 2'h3);
    fm = cpu_ctl_pkg::FM_DIVU;
    opb = 32'h8000_0000;
    res = 32'h0;
    run(cpu_ctl_pkg::OP_FLAGS, 24'h1);
    chk(condition_code_reg[3:2], 2'h2);
    ccr_z_set();
    run(cpu_ctl_pkg::OP_FLAGS, 24'h1);
    chk(condition_code_reg[2], 1'b1);
    res = 32'h1;
    run(cpu_ctl_pkg::OP_FLAGS, 24'h1);
    chk(condition_code_reg[2], 1'b0);
  endtask
  // Zero flag set by a zero divisor before the extended case
  task automatic ccr_z_set();
    fm = cpu_ctl_pkg::FM_DIVU;
    opb = 32'h0;
    run(cpu_ctl_pkg::OP_FLAGS, 24'h1);
    chk(condition_code_reg[2], 1'b1);
    chk(condition_code_reg[3], 1'b0);
    fm = cpu_ctl_pkg::FM_EXT;
    res = 32'h0;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    nrst = 1;
    repeat (2) @(negedge clk);
    chk(condition_code_reg, 8'h80);
    chk(extended_control_reg, 8'h07);
    chk({ready, done, req}, 3'h4);
    logic_ops();
    stores();
    moves();
    flags();
    // Reset while idle restores the condition code register and clears the state count
    nrst = 0;
    repeat (2) @(negedge clk);
    nrst = 1;
    repeat (2) @(negedge clk);
    chk(condition_code_reg, 8'h80);
    chk(states, 24'h0);
    chk({ready, done, req}, 3'h4);
    results();
  end
endmodule
